// >>> rtl/fsad_pkg.sv
// constants, types and decode helpers for the flash security access decode block
package fsad_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int FSAD_ADDR_W = 16;
    localparam int FSAD_DATA_W = 32;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FSAD_SEC_UNSECURE = 2'h2;
    localparam logic [1:0] FSAD_FAC_DENY_A = 2'h1;
    localparam logic [1:0] FSAD_FAC_DENY_B = 2'h2;

    // ------------------------------------------------------------
    // reset values: secure and denied until the option fields are loaded
    // ------------------------------------------------------------
    localparam logic [1:0] FSAD_SEC_RST = 2'h3;
    localparam logic [1:0] FSAD_FAC_RST = 2'h1;
    localparam logic [FSAD_DATA_W-1:0] FSAD_DATA_ZERO = 32'h0000_0000;
    localparam logic [FSAD_ADDR_W-1:0] FSAD_ADDR_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSAD_ST_IDLE = 3'h1,
        FSAD_ST_READ = 3'h2,
        FSAD_ST_RESP = 3'h4
    } fsad_phase_e;

    typedef struct packed {
        logic valid;
        logic [FSAD_ADDR_W-1:0] addr;
    } fsad_ft_req_s;

    typedef struct packed {
        logic valid;
        logic denied;
        logic [FSAD_DATA_W-1:0] data;
    } fsad_ft_rsp_s;

    typedef struct packed {
        logic [1:0] flash_security_state;
        logic [1:0] factory_access_code;
    } fsad_fields_s;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic fsad_is_secure(input logic [1:0] sec);
        return sec != FSAD_SEC_UNSECURE;
    endfunction : fsad_is_secure

    function automatic logic fsad_fac_granted(input logic [1:0] fac);
        return (fac != FSAD_FAC_DENY_A) && (fac != FSAD_FAC_DENY_B);
    endfunction : fsad_fac_granted

endpackage : fsad_pkg

// >>> rtl/fsad_decode.sv
// combinational access decision from the stored security fields
module fsad_decode (
    input wire fsad_pkg::fsad_fields_s fields,
    output logic secure,
    output logic fac_granted,
    output logic access_granted
);
    import fsad_pkg::*;

    // ------------------------------------------------------------
    // decision
    // ------------------------------------------------------------
    // purely combinational so a forced or reloaded field acts at once
    always_comb begin
        secure = fsad_is_secure(fields.flash_security_state);
        fac_granted = fsad_fac_granted(fields.factory_access_code);
        // code only counts while secure
        access_granted = !secure || fac_granted;
    end

endmodule : fsad_decode

// >>> rtl/fsad_access_ctrl.sv
// flash security state keeper and factory-test read gate

// Functional notes
// - the factory access code is weighed only while the part is secure and is ignored when unsecure.
// - code values 01 and 10 mean factory access denied, 00 and 11 mean granted.
// - secure with a denied code refuses factory reads of program flash until a full erase unsecures the part.
// - factory test sees current flash contents when unsecure, or when secure with a granted code.
// - a backdoor key unsecure forces the security state field to 10b.
// - while secure, access to flash module resources is restricted.
module fsad_access_ctrl (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic cfg_load,
    input wire fsad_pkg::fsad_fields_s cfg_fields,
    input wire logic backdoor_unsecure,
    input wire logic full_erase_done,
    input wire fsad_pkg::fsad_ft_req_s ft_req,
    output logic ft_req_ready,
    output fsad_pkg::fsad_ft_rsp_s ft_rsp,
    output logic flash_rd_req,
    output logic [fsad_pkg::FSAD_ADDR_W-1:0] flash_rd_addr,
    input wire logic flash_rd_ack,
    input wire logic [fsad_pkg::FSAD_DATA_W-1:0] flash_rd_data,
    output logic [1:0] flash_security_state,
    output logic [1:0] factory_access_code,
    output logic security_restrict,
    output logic factory_access_granted,
    output logic factory_deny_seen
);
    import fsad_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fsad_fields_s fields;
        fsad_phase_e phase;
        logic [FSAD_ADDR_W-1:0] addr;
        fsad_ft_rsp_s rsp;
        logic deny_seen;
    } fsad_state_s;

    fsad_state_s st;
    fsad_state_s next_st;
    logic secure;
    logic fac_granted;
    logic access_granted;

    // ------------------------------------------------------------
    // decision
    // ------------------------------------------------------------
    fsad_decode u_decode (
        .fields(st.fields),
        .secure(secure),
        .fac_granted(fac_granted),
        .access_granted(access_granted)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rsp.valid = 1'b0;

        // option fields reload the stored copy
        if (cfg_load) begin
            next_st.fields = cfg_fields;
        end
        // erase clears the security and the deny history
        if (full_erase_done) begin
            next_st.fields.flash_security_state = FSAD_SEC_UNSECURE;
            next_st.deny_seen = 1'b0;
        end
        // backdoor applied last so it wins over a same-cycle reload
        if (backdoor_unsecure) begin
            next_st.fields.flash_security_state = FSAD_SEC_UNSECURE;
        end

        unique case (st.phase)
            FSAD_ST_IDLE: begin
                if (ft_req.valid) begin
                    next_st.addr = ft_req.addr;
                    if (access_granted) begin
                        next_st.phase = FSAD_ST_READ;
                    end else begin
                        // refused read answers with zero data, never flash contents
                        next_st.phase = FSAD_ST_RESP;
                        next_st.rsp.denied = 1'b1;
                        next_st.rsp.data = FSAD_DATA_ZERO;
                    end
                end
            end
            FSAD_ST_READ: begin
                if (!access_granted) begin
                    // security rose mid-read: abandon and deny
                    next_st.phase = FSAD_ST_RESP;
                    next_st.rsp.denied = 1'b1;
                    next_st.rsp.data = FSAD_DATA_ZERO;
                end else if (flash_rd_ack) begin
                    next_st.phase = FSAD_ST_RESP;
                    next_st.rsp.denied = 1'b0;
                    next_st.rsp.data = flash_rd_data;
                end
            end
            FSAD_ST_RESP: begin
                next_st.phase = FSAD_ST_IDLE;
                next_st.rsp.valid = 1'b1;
                if (st.rsp.denied && !full_erase_done) begin
                    next_st.deny_seen = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st.fields.flash_security_state <= FSAD_SEC_RST;
            st.fields.factory_access_code <= FSAD_FAC_RST;
            st.phase <= FSAD_ST_IDLE;
            st.addr <= FSAD_ADDR_ZERO;
            st.rsp.valid <= 1'b0;
            st.rsp.denied <= 1'b0;
            st.rsp.data <= FSAD_DATA_ZERO;
            st.deny_seen <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // flash is only driven while granted, so a secure switch cuts the read off at once
    assign flash_rd_req = (st.phase == FSAD_ST_READ) && access_granted;
    assign flash_rd_addr = st.addr;
    assign ft_req_ready = (st.phase == FSAD_ST_IDLE);
    assign ft_rsp = st.rsp;
    assign flash_security_state = st.fields.flash_security_state;
    assign factory_access_code = st.fields.factory_access_code;
    assign security_restrict = secure;
    assign factory_access_granted = access_granted;
    assign factory_deny_seen = st.deny_seen;

endmodule : fsad_access_ctrl

// >>> bench/fsad_flash_model.sv
// flash read partner answering after a chosen number of wait cycles
module fsad_flash_model (
    input wire logic mclk,
    input wire logic flash_rd_req,
    input wire logic [15:0] flash_rd_addr,
    input wire logic [3:0] wait_n,
    output logic flash_rd_ack,
    output logic [31:0] flash_rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt = 4'h0;
    initial flash_rd_ack = 1'b0;
    initial flash_rd_data = 32'h0;
    // idle data toggles so a stale word never passes for an answer
    always @(posedge mclk) begin
        flash_rd_ack <= 1'b0;
        flash_rd_data <= ~flash_rd_data;
        if (flash_rd_req && !flash_rd_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == wait_n) begin
                flash_rd_ack <= 1'b1;
                flash_rd_data <= {~flash_rd_addr, flash_rd_addr};
                cnt <= 4'h0;
            end
        end else if (!flash_rd_req) begin
            // a read cut off by the gate must not leave a half count behind
            cnt <= 4'h0;
        end
    end
endmodule : fsad_flash_model

// >>> bench/fsad_access_ctrl_asserts.sv
// assertions on the ports of the access control block
module fsad_access_ctrl_asserts (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic backdoor_unsecure,
    input wire logic full_erase_done,
    input wire fsad_pkg::fsad_ft_req_s ft_req,
    input wire logic ft_req_ready,
    input wire fsad_pkg::fsad_ft_rsp_s ft_rsp,
    input wire logic flash_rd_req,
    input wire logic flash_rd_ack,
    input wire logic [31:0] flash_rd_data,
    input wire logic [1:0] flash_security_state,
    input wire logic [1:0] factory_access_code,
    input wire logic security_restrict,
    input wire logic factory_access_granted
);
    timeunit 1ns;
    timeprecision 100ps;
    import fsad_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic take;
    assign take = ft_req.valid && ft_req_ready;
    a_restrict_dec: assert property (security_restrict == (flash_security_state != 2'h2))
        else $error("restrict flag wrong");
    a_code_ignored: assert property (!security_restrict |-> factory_access_granted)
        else $error("code weighed while unsecure");
    a_code_decode: assert property (security_restrict |->
        factory_access_granted == (factory_access_code inside {2'h0, 2'h3}))
        else $error("code decode wrong");
    a_backdoor_force: assert property (backdoor_unsecure |=> flash_security_state == 2'h2)
        else $error("backdoor did not unsecure");
    a_erase_unsec: assert property (full_erase_done |=> !security_restrict)
        else $error("erase did not unsecure");
    a_deny_resp: assert property (take && !factory_access_granted |=> ##1
        ft_rsp.valid && ft_rsp.denied && ft_rsp.data == 32'h0)
        else $error("denied answer wrong");
    a_grant_read: assert property (take && factory_access_granted ##1 factory_access_granted
        |-> flash_rd_req) else $error("granted read not issued");
    a_read_data: assert property (flash_rd_req && flash_rd_ack ##1 factory_access_granted
        |=> ft_rsp.valid && !ft_rsp.denied && ft_rsp.data == $past(flash_rd_data, 2))
        else $error("read data not returned");
    c_denied: cover property (ft_rsp.valid && ft_rsp.denied);
    c_granted: cover property (ft_rsp.valid && !ft_rsp.denied);
    c_backdoor: cover property (backdoor_unsecure && security_restrict);
endmodule : fsad_access_ctrl_asserts

bind fsad_access_ctrl fsad_access_ctrl_asserts u_chk (
    .mclk(mclk),
    .arst_n(arst_n),
    .backdoor_unsecure(backdoor_unsecure),
    .full_erase_done(full_erase_done),
    .ft_req(ft_req),
    .ft_req_ready(ft_req_ready),
    .ft_rsp(ft_rsp),
    .flash_rd_req(flash_rd_req),
    .flash_rd_ack(flash_rd_ack),
    .flash_rd_data(flash_rd_data),
    .flash_security_state(flash_security_state),
    .factory_access_code(factory_access_code),
    .security_restrict(security_restrict),
    .factory_access_granted(factory_access_granted)
);

// >>> bench/tb_top.sv
// self-checking bench for the access control block
`define CHK(n, e, a) begin tests_run++; if ((e) !== (a)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fsad_pkg::*;
    logic mclk = 0, arst_n = 0, cfg_load = 0, backdoor_unsecure = 0, full_erase_done = 0;
    fsad_fields_s cfg_fields = '0;
    fsad_ft_req_s ft_req = '0;
    fsad_ft_rsp_s ft_rsp;
    logic ft_req_ready, flash_rd_req, flash_rd_ack, security_restrict, factory_access_granted;
    logic factory_deny_seen;
    bit deny_mdl = 1'b0, hung = 1'b0;
    logic [15:0] flash_rd_addr, a;
    logic [31:0] flash_rd_data;
    logic [1:0] flash_security_state, factory_access_code;
    logic [3:0] wait_n = 4'h0;
    int errors = 0, tests_run = 0, sec = 3, fac = 1, k;
    initial forever #10 mclk = ~mclk;
    fsad_access_ctrl u_dut (.mclk, .arst_n, .cfg_load, .cfg_fields, .backdoor_unsecure,
        .full_erase_done, .ft_req, .ft_req_ready, .ft_rsp, .flash_rd_req, .flash_rd_addr,
        .flash_rd_ack, .flash_rd_data, .flash_security_state, .factory_access_code,
        .security_restrict, .factory_access_granted, .factory_deny_seen);
    fsad_flash_model u_flash (.mclk, .flash_rd_req, .flash_rd_addr, .wait_n, .flash_rd_ack,
        .flash_rd_data);
    function automatic bit mdl_grant();
        return sec == 2 || fac == 0 || fac == 3;
    endfunction : mdl_grant
    task automatic finish_test();
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic check_fields();
        `CHK("state", 2'(sec), flash_security_state)
        `CHK("code", 2'(fac), factory_access_code)
        `CHK("restrict", 1'(sec != 2), security_restrict)
        `CHK("granted", mdl_grant(), factory_access_granted)
        `CHK("deny seen", deny_mdl, factory_deny_seen)
        `CHK("ready", 1'b1, ft_req_ready)
    endtask : check_fields
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge mclk);
        #1 s = 1'b0;
    endtask : pulse
    task automatic do_read(input bit cut);
        ft_req = {1'b1, a};
        @(posedge mclk);
        #1 ft_req.valid = 1'b0;
        `CHK("busy", 1'b0, ft_req_ready)
        if (cut) begin
            // secure and denied lands while the read is still open
            cfg_fields = 4'hD;
            sec = 3;
            fac = 1;
            cfg_load = 1'b1;
            @(posedge mclk);
            #1 cfg_load = 1'b0;
        end
        k = 0;
        // bounded wait: a lost answer must not hang the run
        while (ft_rsp.valid !== 1'b1 && k < 40) begin
            @(posedge mclk);
            #1 k++;
        end
        if (k >= 40) begin
            errors++;
            hung = 1'b1;
        end else begin
            `CHK("denied", !mdl_grant(), ft_rsp.denied)
            `CHK("data", mdl_grant() ? {~a, a} : 32'h0, ft_rsp.data)
            if (!mdl_grant()) begin
                deny_mdl = 1'b1;
            end
        end
    endtask : do_read
    initial begin
        void'($urandom(32'hCBDD));
        repeat (20) @(posedge mclk);
        #1 arst_n = 1'b1;
        check_fields();
        for (int i = 0; i < 300 && !hung; i++) begin
            case ($urandom % 5)
                0, 1: begin
                    cfg_fields = 4'($urandom);
                    sec = cfg_fields.flash_security_state;
                    fac = cfg_fields.factory_access_code;
                    pulse(cfg_load);
                end
                2: begin
                    // a reload in the same cycle keeps its code but not its state
                    cfg_fields = 4'($urandom);
                    cfg_load = 1'($urandom);
                    if (cfg_load) begin
                        fac = cfg_fields.factory_access_code;
                    end
                    sec = 2;
                    backdoor_unsecure = 1'b1;
                    @(posedge mclk);
                    #1 backdoor_unsecure = 1'b0;
                    cfg_load = 1'b0;
                end
                3: begin
                    sec = 2;
                    deny_mdl = 1'b0;
                    pulse(full_erase_done);
                end
                default: begin
                    a = 16'($urandom);
                    wait_n = 4'($urandom % 4);
                    do_read(($urandom % 4) == 0);
                end
            endcase
            check_fields();
        end
        finish_test();
    end
endmodule : tb_top
